// ---- bench/xig_glue_sva.sv ----
// Port checker for the interrupt glue.
`timescale 1ns/1ns
`default_nettype none
module xig_glue_sva
   import xig_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic [15:0] isaAddr,
   input wire logic ioRead,
   input wire logic ioWrite,
   input wire logic [7:0] dataIn,
   input wire logic generalChipSelect,
   input wire logic [CTRL_COUNT-1:0] ctrlSelect,
   input wire logic ackStrobe_n,
   input wire logic ioChRdyOe,
   input wire logic handlingDone,
   input wire logic bankJumper,
   input wire logic flashVppEnable,
   input wire logic flashA17,
   input wire logic flashA18,
   input wire logic flashBank
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   logic fetchRd;
   logic highWr;
   assign fetchRd = ioRead && isaAddr == VECTOR_FETCH_ADDR;
   assign highWr = ioWrite && isaAddr == EDGE_LEVEL_HIGH_ADDR;
   AST_SEL_OFF:
      assert property (!generalChipSelect |-> ctrlSelect == 5'h00) else $error("stray select");
   AST_SEL_SLAVE3:
      assert property (generalChipSelect && isaAddr[3:0] == SEL_SLAVE3_HI |-> ctrlSelect == 5'h10) else $error("bad select");
   AST_FETCH_HOLD:
      assert property ($rose(ioRead) && fetchRd |-> ioChRdyOe ##40 ioChRdyOe) else $error("ready not held");
   AST_RELEASE:
      assert property ($rose(ioRead) && fetchRd |-> ##80 ioChRdyOe ##1 !ioChRdyOe) else $error("ready release");
   AST_PULSE_ONE:
      assert property ($rose(ioRead) && fetchRd |-> ##1 !ackStrobe_n ##19 !ackStrobe_n ##1 ackStrobe_n)
         else $error("first pulse");
   AST_PULSE_TWO:
      assert property ($rose(ioRead) && fetchRd |-> ##41 !ackStrobe_n ##19 !ackStrobe_n ##1 ackStrobe_n)
         else $error("second pulse");
   AST_DONE:
      assert property (handlingDone |-> !ioRead && !ioChRdyOe && ackStrobe_n ##1 !handlingDone) else $error("done");
   AST_VPP:
      assert property (highWr |=> flashVppEnable == $past(dataIn[VPP_ENABLE_BIT])) else $error("vpp");
   AST_FLASH_ADDR:
      assert property (highWr |=> {flashA18, flashA17} == $past(dataIn[6:5])) else $error("flash address");
   AST_BANK:
      assert property (bankJumper |-> flashBank) else $error("bank jumper");
   cover property ($rose(ioRead) && fetchRd);
   cover property (handlingDone);
   cover property (highWr && bankJumper);
endmodule // xig_glue_sva
bind xig_interrupt_glue xig_glue_sva xig_glue_sva_inst (.*);
`default_nettype wire

// ---- bench/xig_interrupt_glue_tb.sv ----
// Self-checking testbench for the interrupt glue.
`timescale 1ns/1ns
`default_nettype none
module xig_interrupt_glue_tb import xig_pkg::*;;
   logic mclk, srst, ioRead, ioWrite, generalChipSelect, ackStrobe_n, ioChRdyOut, ioChRdyOe, handlingDone;
   logic bankJumper, flashVppEnable, flashA17, flashA18, flashBank, dataOe;
   logic [15:0] isaAddr;
   logic [7:0] dataIn, dataOut, q;
   logic [4:0] ctrlSelect, lastSel;
   logic lastOe;
   logic [10:0] eisaIrqLine, eisaIrqToCtrl;
   logic [13:0] pciIrqLine_n, pciIrqToCtrl;
   logic [3:0] nib [5] = '{SEL_MASTER_LO, SEL_SLAVE0_HI, SEL_SLAVE1_LO, SEL_SLAVE2_HI, SEL_SLAVE3_HI};
   int miscompares = 0, num_checks = 0, n, ackLows;
   xig_interrupt_glue #(.PCI_IRQ_COUNT(14)) xig_interrupt_glue_inst (.*);
   xig_isa_host xig_isa_host_inst (.*);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (ioRead) lastSel <= ctrlSelect;
      if (ioRead) lastOe <= dataOe;
      if (!ackStrobe_n) ackLows <= ackLows + 1;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic [15:0] a, input logic rd, input logic [7:0] wd);
      xig_isa_host_inst.cycle(a, rd, wd, q, n);
      if (n >= 300) begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   initial begin
      {srst, bankJumper, eisaIrqLine, pciIrqLine_n, ackLows} = {2'b10, 11'h7ff, 14'h3fff, 32'h0};
      tick(3);
      srst = 1'b0;
      bus(EDGE_LEVEL_LOW_ADDR, 1'b1, 8'h00);
      check("low reset", q, 16'h0000);
      bus(EDGE_LEVEL_HIGH_ADDR, 1'b1, 8'h00);
      check("high reset", {q, flashBank, flashA18, flashA17, flashVppEnable}, 16'h0000);
      bus(EDGE_LEVEL_HIGH_ADDR, 1'b0, 8'hff);
      bus(EDGE_LEVEL_HIGH_ADDR, 1'b1, 8'h00);
      check("high readback", {q, flashBank, flashA18, flashA17, flashVppEnable}, 16'h0f7f);
      bus(EDGE_LEVEL_HIGH_ADDR, 1'b0, 8'h00);
      bankJumper = 1'b1;
      bus(EDGE_LEVEL_HIGH_ADDR, 1'b1, 8'h00);
      check("bank jumper", {q, flashBank}, 16'h0101);
      bankJumper = 1'b0;
      bus(EDGE_LEVEL_LOW_ADDR, 1'b0, 8'ha5);
      bus(EDGE_LEVEL_LOW_ADDR, 1'b1, 8'h00);
      check("low readback", q, 16'h00a5);
      check("read enable", lastOe, 16'h0001);
      tick(2);
      check("idle lines", eisaIrqToCtrl, 16'h075a);
      eisaIrqLine = 11'h7fc;
      pciIrqLine_n = 14'h3ffe;
      tick(2);
      check("active lines", {pciIrqToCtrl, eisaIrqToCtrl}, {14'h0001, 11'h759});
      foreach (nib[k]) begin
         bus({12'h053, nib[k]}, 1'b1, 8'h00);
         check("select", lastSel, 16'h1 << k);
      end
      bus(16'h0530, 1'b1, 8'h00);
      check("unmapped select", lastSel, 16'h0000);
      ackLows = 0;
      bus(VECTOR_FETCH_ADDR, 1'b1, 8'h00);
      check("ready wait", n, 2 * ACK_PULSE_CYCLES + ACK_GAP_CYCLES + VECTOR_VALID_CYCLES + 1);
      check("ack low cycles", ackLows, 2 * ACK_PULSE_CYCLES);
      check("fetch read enable", lastOe, 16'h0000);
      check("ready level", ioChRdyOut, 16'h0000);
      #1;
      check("handling done", handlingDone, 16'h0001);
      tick(3);
      check("edge low", {eisaIrqToCtrl[0], pciIrqToCtrl[0]}, 16'h0000);
      tick(REEDGE_LOW_CYCLES + 2);
      check("edge high", {eisaIrqToCtrl[0], pciIrqToCtrl[0]}, 16'h0003);
      complete_run();
   end
endmodule // xig_interrupt_glue_tb
`default_nettype wire

// ---- bench/xig_isa_host.sv ----
// Bus master model running register and vector fetch cycles.
`timescale 1ns/1ns
`default_nettype none
module xig_isa_host
   import xig_pkg::*;
(
   input wire logic mclk,
   input wire logic [7:0] dataOut,
   input wire logic ioChRdyOe,
   output logic [15:0] isaAddr,
   output logic ioRead,
   output logic ioWrite,
   output logic [7:0] dataIn,
   output logic generalChipSelect
);
   initial begin
      {isaAddr, ioRead, ioWrite, dataIn, generalChipSelect} = '0;
   end
   // Holds the cycle while ready is pulled low; the count bound keeps a stuck slave from hanging us.
   task automatic cycle(input logic [15:0] a, input logic rd, input logic [7:0] wd, output logic [7:0] q,
         output int n);
      n = 0;
      @(posedge mclk);
      #1;
      isaAddr = a;
      generalChipSelect = a[15:4] == 12'h053;
      ioRead = rd;
      ioWrite = !rd;
      dataIn = wd;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (ioChRdyOe && n < 300);
      q = dataOut;
      {ioRead, ioWrite, generalChipSelect} = 3'h0;
      // A released bus must not keep showing the last value.
      isaAddr = ~a;
      dataIn = ~wd;
   endtask
endmodule // xig_isa_host
`default_nettype wire

// ---- hdl/xig_interrupt_glue.sv ----
// Bus glue between the buffered slave bus and a cascade of priority interrupt controllers.
// Notes on behaviour
// R1: One master controller with four slaves, each slave on a master cascade input.
// R2: Chip select 0 plus low address nibble gives each controller its own select.
// R3: Controllers answer register accesses as bus slaves through their selects.
// R4: A read of I/O address 0032h is the only way to fetch a vector.
// R5: A vector fetch makes two acknowledge pulses; the slave drives vector on second.
// R6: The acknowledge state machine holds channel ready deasserted during the fetch.
// R7: Channel ready is released only once the vector is valid after pulse two.
// R8: Every controller input is rising-edge triggered; no mixed modes.
// R9: PCI interrupt inputs are active-low level requests.
// R10: Two 8-bit registers; a set bit makes that EISA interrupt level triggered.
// R11: Low register maps IRQ 3-7,9-11; high bits 0-2 map 12,14,15; bit 3 unused.
// R12: Level requests are inverted so the controller sees a rising edge.
// R13: A level request still held when handling ends gets a further edge.
// R14: High register bit 4 drives the flash programming voltage enable.
// R15: High register bits 7,6,5 drive flash bank, a18 and a17.
// R16: Flash bank bit reads set whenever the bank jumper is installed.
// R17: Both registers clear to zero on reset.
// R18: Registers read back last written value, unused bit reads zero.
`timescale 1ns/1ns
`default_nettype none
module xig_interrupt_glue
   import xig_pkg::*;
#(
   parameter int PCI_IRQ_COUNT = 14
)
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic [15:0] isaAddr,
   input wire logic ioRead,
   input wire logic ioWrite,
   input wire logic [7:0] dataIn,
   input wire logic generalChipSelect,
   output logic [7:0] dataOut,
   output logic dataOe,
   output logic [CTRL_COUNT-1:0] ctrlSelect,
   output logic ackStrobe_n,
   output logic ioChRdyOut,
   output logic ioChRdyOe,
   input wire logic [EISA_IRQ_COUNT-1:0] eisaIrqLine,
   input wire logic [PCI_IRQ_COUNT-1:0] pciIrqLine_n,
   output logic [EISA_IRQ_COUNT-1:0] eisaIrqToCtrl,
   output logic [PCI_IRQ_COUNT-1:0] pciIrqToCtrl,
   output logic handlingDone,
   input wire logic bankJumper,
   output logic flashVppEnable,
   output logic flashA17,
   output logic flashA18,
   output logic flashBank
);
   logic [7:0] edgeLevelCtrlLow;
   logic [7:0] edgeLevelCtrlHigh;
   logic [7:0] next_edgeLevelCtrlLow;
   logic [7:0] next_edgeLevelCtrlHigh;
   logic [7:0] next_dataOut;
   logic [7:0] highReadValue;
   logic lowHit;
   logic highHit;
   logic fetchRequest;
   logic [3:0] nib;
   xig_fetch_e fetchState;
   xig_fetch_e next_fetchState;
   logic [TIMER_WIDTH-1:0] timer;
   logic [TIMER_WIDTH-1:0] next_timer;
   logic [EISA_IRQ_COUNT-1:0] eisaLevelMode;

   assign nib = isaAddr[3:0];

   // Selects are combinational so the controllers see the access in the same bus cycle.
   always_comb begin
      ctrlSelect = '0;
      if (generalChipSelect && (nib == SEL_MASTER_LO || nib == SEL_MASTER_HI)) begin
         ctrlSelect[0] = 1'b1; // [R2] [R3] [R1]
      end else if (generalChipSelect && (nib == SEL_SLAVE0_LO || nib == SEL_SLAVE0_HI)) begin
         ctrlSelect[1] = 1'b1; // [R2] [R3]
      end else if (generalChipSelect && (nib == SEL_SLAVE1_LO || nib == SEL_SLAVE1_HI)) begin
         ctrlSelect[2] = 1'b1; // [R2] [R3]
      end else if (generalChipSelect && (nib == SEL_SLAVE2_LO || nib == SEL_SLAVE2_HI)) begin
         ctrlSelect[3] = 1'b1; // [R2] [R3]
      end else if (generalChipSelect && (nib == SEL_SLAVE3_LO || nib == SEL_SLAVE3_HI)) begin
         ctrlSelect[4] = 1'b1; // [R2] [R3]
      end
   end

   assign lowHit = (isaAddr == EDGE_LEVEL_LOW_ADDR);
   assign highHit = (isaAddr == EDGE_LEVEL_HIGH_ADDR);

   // The unused bit is forced low and the jumper overrides the bank bit on read.
   always_comb begin
      highReadValue = edgeLevelCtrlHigh & HIGH_READ_MASK; // [R18]
      highReadValue[FLASH_BANK_BIT] = edgeLevelCtrlHigh[FLASH_BANK_BIT] | bankJumper; // [R16]
   end

   always_comb begin
      next_edgeLevelCtrlLow = edgeLevelCtrlLow;
      next_edgeLevelCtrlHigh = edgeLevelCtrlHigh;
      next_dataOut = dataOut;
      if (ioWrite && lowHit) begin
         next_edgeLevelCtrlLow = dataIn; // [R10]
      end else if (ioWrite && highHit) begin
         next_edgeLevelCtrlHigh = dataIn & HIGH_READ_MASK; // [R10] [R18]
      end
      if (lowHit) begin
         next_dataOut = edgeLevelCtrlLow; // [R18]
      end else if (highHit) begin
         next_dataOut = highReadValue; // [R18]
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         edgeLevelCtrlLow <= EDGE_LEVEL_RESET; // [R17]
         edgeLevelCtrlHigh <= EDGE_LEVEL_RESET; // [R17]
         dataOut <= 8'h00;
      end else begin
         edgeLevelCtrlLow <= next_edgeLevelCtrlLow;
         edgeLevelCtrlHigh <= next_edgeLevelCtrlHigh;
         dataOut <= next_dataOut;
      end
   end

   // Read data lags the address by one clock; the slow bus cycle hides this.
   assign dataOe = ioRead && (lowHit || highHit);

   assign flashVppEnable = edgeLevelCtrlHigh[VPP_ENABLE_BIT]; // [R14]
   assign flashA17 = edgeLevelCtrlHigh[FLASH_A17_BIT]; // [R15]
   assign flashA18 = edgeLevelCtrlHigh[FLASH_A18_BIT]; // [R15]
   assign flashBank = edgeLevelCtrlHigh[FLASH_BANK_BIT] | bankJumper; // [R15] [R16]

   assign fetchRequest = ioRead && (isaAddr == VECTOR_FETCH_ADDR); // [R4]

   always_comb begin
      next_fetchState = fetchState;
      next_timer = timer;
      if (timer != '0) begin
         next_timer = timer - 1'b1;
      end
      case (fetchState)
         XIG_IDLE: begin
            if (fetchRequest) begin
               next_fetchState = XIG_PULSE1; // [R4] [R5]
               next_timer = TIMER_WIDTH'(ACK_PULSE_CYCLES - 1);
            end
         end
         XIG_PULSE1: begin
            if (timer == '0) begin
               next_fetchState = XIG_GAP;
               next_timer = TIMER_WIDTH'(ACK_GAP_CYCLES - 1);
            end
         end
         XIG_GAP: begin
            if (timer == '0) begin
               next_fetchState = XIG_PULSE2; // [R5]
               next_timer = TIMER_WIDTH'(ACK_PULSE_CYCLES - 1);
            end
         end
         XIG_PULSE2: begin
            if (timer == '0) begin
               next_fetchState = XIG_SETTLE; // [R7]
               next_timer = TIMER_WIDTH'(VECTOR_VALID_CYCLES - 1);
            end
         end
         XIG_SETTLE: begin
            if (timer == '0) begin
               next_fetchState = XIG_RELEASE; // [R7]
            end
         end
         XIG_RELEASE: begin
            // Waiting for the read to end keeps one bus read from starting two fetches.
            if (!ioRead) begin
               next_fetchState = XIG_IDLE;
            end
         end
         default: begin
            next_fetchState = XIG_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         fetchState <= XIG_IDLE;
         timer <= '0;
      end else begin
         fetchState <= next_fetchState;
         timer <= next_timer;
      end
   end

   assign ackStrobe_n = !(fetchState == XIG_PULSE1 || fetchState == XIG_PULSE2); // [R5]
   // Ready is pulled low from the request until the vector has settled. [R6] [R7]
   assign ioChRdyOut = 1'b0;
   assign ioChRdyOe = (fetchState == XIG_PULSE1) || (fetchState == XIG_GAP) || (fetchState == XIG_PULSE2)
      || (fetchState == XIG_SETTLE) || ((fetchState == XIG_IDLE) && fetchRequest); // [R6] [R7]
   assign handlingDone = (fetchState == XIG_RELEASE) && !ioRead; // [R13]

   assign eisaLevelMode = {edgeLevelCtrlHigh[HIGH_REG_IRQS-1:0], edgeLevelCtrlLow[LOW_REG_IRQS-1:0]}; // [R11]

   // All outputs feed edge-triggered controller inputs only. [R8]
   genvar gi;
   generate
      for (gi = 0; gi < EISA_IRQ_COUNT; gi++) begin : g_eisa
         xig_level_cond u_cond (
            .mclk(mclk),
            .srst(srst),
            .irqLine(eisaIrqLine[gi]),
            .levelMode(eisaLevelMode[gi]), // [R10] [R11]
            .handlingDone(handlingDone),
            .condOut(eisaIrqToCtrl[gi])
         );
      end
      for (gi = 0; gi < PCI_IRQ_COUNT; gi++) begin : g_pci
         xig_level_cond u_cond (
            .mclk(mclk),
            .srst(srst),
            .irqLine(pciIrqLine_n[gi]),
            .levelMode(1'b1), // [R9]
            .handlingDone(handlingDone),
            .condOut(pciIrqToCtrl[gi])
         );
      end
   endgenerate
endmodule : xig_interrupt_glue
`default_nettype wire

// ---- hdl/xig_level_cond.sv ----
// One interrupt line conditioner: edge pass-through or level-to-edge conversion.
`timescale 1ns/1ns
`default_nettype none
module xig_level_cond
   import xig_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic irqLine,
   input wire logic levelMode,
   input wire logic handlingDone,
   output logic condOut
);
   logic [TIMER_WIDTH-1:0] lowCount;
   logic [TIMER_WIDTH-1:0] next_lowCount;
   logic levelActive;

   // An active-low level request becomes a high level for the edge controller. [R12]
   assign levelActive = ~irqLine;

   // A level request still held when handling ends is dropped briefly, giving a fresh rising edge. [R13]
   always_comb begin
      next_lowCount = lowCount;
      if (lowCount != '0) begin
         next_lowCount = lowCount - 1'b1;
      end else if (handlingDone && levelMode && levelActive) begin
         next_lowCount = TIMER_WIDTH'(REEDGE_LOW_CYCLES);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         lowCount <= '0;
         condOut <= 1'b0;
      end else begin
         lowCount <= next_lowCount;
         condOut <= levelMode ? (levelActive && (next_lowCount == '0)) : irqLine; // [R12] [R10]
      end
   end
endmodule : xig_level_cond
`default_nettype wire

// ---- hdl/xig_pkg.sv ----
// Constants shared by the interrupt glue design.
package xig_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam logic [15:0] VECTOR_FETCH_ADDR = 16'h0032;
   localparam logic [15:0] EDGE_LEVEL_LOW_ADDR = 16'h04d0;
   localparam logic [15:0] EDGE_LEVEL_HIGH_ADDR = 16'h04d1;
   localparam logic [3:0] SEL_MASTER_LO = 4'h4;
   localparam logic [3:0] SEL_MASTER_HI = 4'h5;
   localparam logic [3:0] SEL_SLAVE0_LO = 4'h6;
   localparam logic [3:0] SEL_SLAVE0_HI = 4'h7;
   localparam logic [3:0] SEL_SLAVE1_LO = 4'ha;
   localparam logic [3:0] SEL_SLAVE1_HI = 4'hb;
   localparam logic [3:0] SEL_SLAVE2_LO = 4'hc;
   localparam logic [3:0] SEL_SLAVE2_HI = 4'hd;
   localparam logic [3:0] SEL_SLAVE3_LO = 4'he;
   localparam logic [3:0] SEL_SLAVE3_HI = 4'hf;
   localparam int CTRL_COUNT = 5;
   localparam int EISA_IRQ_COUNT = 11;
   localparam int LOW_REG_IRQS = 8;
   localparam int HIGH_REG_IRQS = 3;
   localparam int HIGH_UNUSED_BIT = 3;
   localparam int VPP_ENABLE_BIT = 4;
   localparam int FLASH_A17_BIT = 5;
   localparam int FLASH_A18_BIT = 6;
   localparam int FLASH_BANK_BIT = 7;
   localparam logic [7:0] EDGE_LEVEL_RESET = 8'h00;
   localparam logic [7:0] HIGH_READ_MASK = 8'hf7;
   localparam int ACK_PULSE_NS = 200;
   localparam int ACK_GAP_NS = 200;
   localparam int VECTOR_VALID_NS = 200;
   localparam int REEDGE_LOW_NS = 100;
   localparam int ACK_PULSE_CYCLES = (ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_GAP_CYCLES = (ACK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int VECTOR_VALID_CYCLES = (VECTOR_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REEDGE_LOW_CYCLES = (REEDGE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_WIDTH = 8;
   typedef enum logic [2:0] {
      XIG_IDLE,
      XIG_PULSE1,
      XIG_GAP,
      XIG_PULSE2,
      XIG_SETTLE,
      XIG_RELEASE
   } xig_fetch_e;
endpackage : xig_pkg
